//--- logic/sstm_pkg.sv
// Purpose: Constants for the SS7 error-rate and transparent channel block
// Assumes: 10 MHz system clock, 32-bit Avalon-MM register bus
// Notes: Byte address of each register is a multiple of four
package sstm_pkg;
  // =====================================================
  // Register map
  localparam logic [4:0] ADDR_CTRL = 5'h00;
  localparam logic [4:0] ADDR_TX_DESC = 5'h04;
  localparam logic [4:0] ADDR_TX_DATA = 5'h08;
  localparam logic [4:0] ADDR_RX_DESC = 5'h0c;
  localparam logic [4:0] ADDR_RX_DATA = 5'h10;
  localparam logic [4:0] ADDR_STATUS = 5'h14;
  localparam logic [4:0] ADDR_EVENT = 5'h18;
  // =====================================================
  // Control fields
  localparam int CTRL_TX_TRANSP = 0;
  localparam int CTRL_RX_TRANSP = 1;
  localparam int CTRL_SS7 = 2;
  localparam int CTRL_ALARM_MASK = 3;
  localparam int CTRL_FRAME_MASK = 4;
  localparam int CTRL_ACTIVATE = 5;
  localparam int CTRL_THR_LSB = 8;
  localparam int DESC_IRQ_EN = 14;
  localparam int DESC_OWNER = 15;
  localparam int EVT_VALID = 16;
  localparam logic [7:0] THR_RESET = 8'h10;
  // =====================================================
  // Counting
  localparam logic [3:0] OCTET_ERR_LAST = 4'hf;
  localparam logic [7:0] GOOD_MSG_LAST = 8'hff;
  localparam logic [7:0] CNT_MAX = 8'hff;
  // =====================================================
  // Interrupt descriptor codes
  localparam logic [3:0] CODE_SU_ERR = 4'h1;
  localparam logic [3:0] CODE_END_BUF = 4'h2;
  localparam logic [3:0] CODE_OWNED_ERR = 4'h3;
  localparam logic [3:0] CODE_FRAME_REC = 4'h4;
  localparam int EVT_NUM = 5;
  localparam int QDEPTH = 4;
endpackage : sstm_pkg

//--- logic/sstm_channel.sv
// Purpose: One SS7/transparent channel with event queue and register slave
// Assumes: line clock far slower than clk; SS7 message strobes on clk
// Notes: Transmit data bits change on line clock fall, receive on rise
`timescale 1ns/1ns
module sstm_channel import sstm_pkg::*; #(
  parameter logic [3:0] CHANNEL_ID = 4'h0 // Arbitrary channel number
) (
  input wire logic clk, // System clock
  input wire logic rst_n, // Async reset
  input wire logic [4:0] address, // Byte address
  input wire logic read, // Read request
  input wire logic write, // Write request
  input wire logic [31:0] writedata, // Write data
  output logic [31:0] readdata, // Read data
  output logic waitrequest, // Stall
  input wire logic line_clk, // Serial clock
  input wire logic line_rx, // Serial receive data
  input wire logic line_in_frame, // Framer in-frame
  output logic line_tx, // Serial transmit data
  input wire logic ss7_msg_ok, // Good SS7 message
  input wire logic ss7_msg_short, // Short message
  input wire logic ss7_msg_fcs, // Frame check error
  input wire logic ss7_msg_align, // Alignment error
  input wire logic ss7_octet_err, // Octet count error
  output logic flag_hunt_restart // Restart flag hunt
);
  // =====================================================
  // Reset and input synchronisers
  logic [1:0] rst_sync;
  logic rst_core_n;
  logic [2:0] clk_sync;
  logic [1:0] rx_sync;
  logic [2:0] frm_sync;
  assign rst_core_n = rst_sync[1];
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  always_ff @(posedge clk or negedge rst_core_n) begin
    if (!rst_core_n) begin
      clk_sync <= 3'h0;
      rx_sync <= 2'h0;
      frm_sync <= 3'h0;
    end else begin
      clk_sync <= {clk_sync[1:0], line_clk};
      rx_sync <= {rx_sync[0], line_rx};
      frm_sync <= {frm_sync[1:0], line_in_frame};
    end
  end
  wire line_rise = clk_sync[1] & ~clk_sync[2];
  wire line_fall = ~clk_sync[1] & clk_sync[2];
  wire frame_rise = frm_sync[1] & ~frm_sync[2];
  // =====================================================
  // Register state
  logic tx_transp, rx_transp, ss7_en, alarm_mask, frame_mask;
  logic [7:0] err_thr;
  logic tx_active;
  logic [13:0] tx_len, rx_len, tx_cnt, rx_cnt;
  logic tx_irq_en, tx_owner, rx_irq_en, rx_owner;
  logic [7:0] tx_hold, tx_shift, rx_shift, rx_data;
  logic tx_hold_valid, rx_valid;
  logic [3:0] tx_left;
  logic [2:0] rx_bits;
  logic [7:0] ss7_cnt, good_cnt;
  logic [3:0] octet_cnt;
  logic alarm_prev;
  logic [EVT_NUM-1:0] pend;
  logic [8:0] queue [QDEPTH];
  logic [1:0] q_head, q_tail;
  logic [2:0] q_count;
  // =====================================================
  // Bus decode
  wire req = read | write;
  wire acc = req & ~waitrequest;
  wire wr_ctrl = acc & write & (address == ADDR_CTRL);
  wire wr_txd = acc & write & (address == ADDR_TX_DESC);
  wire wr_txdata = acc & write & (address == ADDR_TX_DATA);
  wire wr_rxd = acc & write & (address == ADDR_RX_DESC);
  wire rd_rxdata = acc & read & (address == ADDR_RX_DATA);
  wire rd_event = acc & read & (address == ADDR_EVENT);
  wire activate = wr_ctrl & writedata[CTRL_ACTIVATE];
  wire tx_feeding = tx_active & tx_transp & tx_owner;
  // Back-pressure while the one-byte holding stage is full
  wire tx_stall = write & (address == ADDR_TX_DATA) & tx_hold_valid & tx_feeding;
  wire next_waitrequest = ~(req & waitrequest & ~tx_stall);
  wire q_empty = (q_count == 3'h0);
  wire [31:0] status_word = {16'h0, ss7_cnt, 3'h0, q_empty, rx_valid, tx_hold_valid, alarm_prev, tx_active};
  logic [31:0] next_readdata;
  always_comb begin
    case (address)
      ADDR_CTRL: next_readdata = {16'h0, err_thr, 3'h0, frame_mask, alarm_mask, ss7_en, rx_transp, tx_transp};
      ADDR_TX_DESC: next_readdata = {16'h0, tx_owner, tx_irq_en, tx_len};
      ADDR_RX_DESC: next_readdata = {16'h0, rx_owner, rx_irq_en, rx_len};
      ADDR_RX_DATA: next_readdata = {23'h0, rx_valid, rx_data};
      ADDR_STATUS: next_readdata = status_word;
      ADDR_EVENT: next_readdata = q_empty ? 32'h0 : {15'h0, 1'b1, 7'h0, queue[q_head]};
      default: next_readdata = 32'h0;
    endcase
  end
  always_ff @(posedge clk or negedge rst_core_n) begin
    if (!rst_core_n) begin
      waitrequest <= 1'b1;
      readdata <= 32'h0;
    end else begin
      waitrequest <= next_waitrequest;
      readdata <= next_readdata;
    end
  end
  // =====================================================
  // Transmit path
  wire tx_accept = wr_txdata & tx_feeding;
  wire tx_last = tx_accept & (tx_cnt + 14'h1 == tx_len);
  wire tx_need = line_fall & tx_active & tx_transp & (tx_left == 4'h0) & ~tx_hold_valid;
  // Descriptor ownership looked at only when data is due
  wire tx_owned_err = tx_need & ~tx_owner;
  always_ff @(posedge clk or negedge rst_core_n) begin
    if (!rst_core_n) begin
      {tx_transp, rx_transp, ss7_en, alarm_mask, frame_mask, tx_active} <= 6'h0;
      err_thr <= THR_RESET;
      {tx_len, tx_irq_en, tx_owner, tx_cnt} <= 30'h0;
      {tx_hold, tx_shift, tx_hold_valid, tx_left} <= 21'h0;
      line_tx <= 1'b1;
    end else begin
      if (wr_ctrl) begin
        {frame_mask, alarm_mask, ss7_en, rx_transp, tx_transp} <= writedata[4:0];
        err_thr <= writedata[CTRL_THR_LSB +: 8];
      end
      if (wr_txd) begin
        {tx_owner, tx_irq_en, tx_len} <= writedata[15:0];
        tx_cnt <= 14'h0;
      end else if (tx_last) begin
        tx_owner <= 1'b0;
        tx_cnt <= 14'h0;
      end else if (tx_accept) begin
        tx_cnt <= tx_cnt + 14'h1;
      end
      if (tx_owned_err) begin
        tx_active <= 1'b0;
      end else if (activate) begin
        tx_active <= 1'b1;
      end
      if (tx_accept) begin
        tx_hold <= writedata[7:0];
        tx_hold_valid <= 1'b1;
      end else if (line_fall & (tx_left == 4'h0) & tx_hold_valid) begin
        tx_hold_valid <= 1'b0;
      end
      // Raw bits out; no flag or stuffing, no idle-flag state
      if (line_fall) begin
        if (!(tx_active & tx_transp)) begin
          line_tx <= 1'b1;
        end else if (tx_left != 4'h0) begin
          line_tx <= tx_shift[7];
          tx_shift <= {tx_shift[6:0], 1'b0};
          tx_left <= tx_left - 4'h1;
        end else if (tx_hold_valid) begin
          line_tx <= tx_hold[7];
          tx_shift <= {tx_hold[6:0], 1'b0};
          tx_left <= 4'h7;
        end else begin
          line_tx <= 1'b1;
        end
      end
    end
  end
  // =====================================================
  // Receive path
  wire rx_take = line_rise & rx_transp & rx_owner & frm_sync[2];
  wire rx_byte = rx_take & (rx_bits == 3'h7);
  wire rx_last = rx_byte & (rx_cnt + 14'h1 == rx_len);
  always_ff @(posedge clk or negedge rst_core_n) begin
    if (!rst_core_n) begin
      {rx_len, rx_irq_en, rx_owner, rx_cnt} <= 30'h0;
      {rx_shift, rx_data, rx_valid, rx_bits} <= 20'h0;
    end else begin
      if (wr_rxd) begin
        {rx_owner, rx_irq_en, rx_len} <= writedata[15:0];
        rx_cnt <= 14'h0;
      end else if (rx_last) begin
        rx_owner <= 1'b0;
        rx_cnt <= 14'h0;
      end else if (rx_byte) begin
        rx_cnt <= rx_cnt + 14'h1;
      end
      if (frame_rise) begin
        rx_bits <= 3'h0;
      end else if (rx_take) begin
        rx_shift <= {rx_shift[6:0], rx_sync[1]};
        rx_bits <= rx_bits + 3'h1;
      end
      if (rx_byte) begin
        rx_data <= {rx_shift[6:0], rx_sync[1]};
      end
      rx_valid <= rx_byte | (rx_valid & ~rd_rxdata);
    end
  end
  // =====================================================
  // SS7 error-rate counter
  wire hard_err = ss7_en & (ss7_msg_short | ss7_msg_fcs | ss7_msg_align);
  wire octet_inc = ss7_en & ss7_octet_err & (octet_cnt == OCTET_ERR_LAST);
  wire good_dec = ss7_en & ss7_msg_ok & (good_cnt == GOOD_MSG_LAST);
  wire cnt_up = hard_err | octet_inc;
  wire alarm_level = ss7_en & (ss7_cnt >= err_thr);
  wire alarm_event = alarm_level & ~alarm_prev;
  always_ff @(posedge clk or negedge rst_core_n) begin
    if (!rst_core_n) begin
      {ss7_cnt, good_cnt, octet_cnt, alarm_prev} <= 21'h0;
      flag_hunt_restart <= 1'b0;
    end else begin
      if (activate) begin
        {ss7_cnt, good_cnt, octet_cnt} <= 20'h0;
      end else begin
        if (cnt_up & ~good_dec & (ss7_cnt != CNT_MAX)) begin
          ss7_cnt <= ss7_cnt + 8'h1;
        end else if (good_dec & ~cnt_up & (ss7_cnt != 8'h0)) begin
          ss7_cnt <= ss7_cnt - 8'h1;
        end
        if (ss7_en & ss7_octet_err) begin
          octet_cnt <= octet_cnt + 4'h1;
        end
        if (ss7_en & ss7_msg_ok) begin
          good_cnt <= good_cnt + 8'h1;
        end
      end
      alarm_prev <= alarm_level;
      flag_hunt_restart <= alarm_event;
    end
  end
  // =====================================================
  // Interrupt descriptor queue
  // Pending flags let simultaneous events queue one per cycle
  wire [EVT_NUM-1:0] evt_set = {
    frame_rise & ~frame_mask,
    rx_last & rx_irq_en,
    tx_owned_err,
    tx_last & tx_irq_en,
    alarm_event & ~alarm_mask};
  wire q_full = (q_count == 3'(QDEPTH));
  logic [EVT_NUM-1:0] evt_clr;
  logic [8:0] evt_word;
  always_comb begin
    evt_clr = '0;
    evt_word = {CHANNEL_ID, 1'b0, CODE_SU_ERR};
    if (!q_full) begin
      if (pend[0]) begin
        evt_clr[0] = 1'b1;
      end else if (pend[1]) begin
        evt_clr[1] = 1'b1;
        evt_word = {CHANNEL_ID, 1'b1, CODE_END_BUF};
      end else if (pend[2]) begin
        evt_clr[2] = 1'b1;
        evt_word = {CHANNEL_ID, 1'b1, CODE_OWNED_ERR};
      end else if (pend[3]) begin
        evt_clr[3] = 1'b1;
        evt_word = {CHANNEL_ID, 1'b0, CODE_END_BUF};
      end else if (pend[4]) begin
        evt_clr[4] = 1'b1;
        evt_word = {CHANNEL_ID, 1'b0, CODE_FRAME_REC};
      end
    end
  end
  wire push = |evt_clr;
  wire pop = rd_event & ~q_empty;
  always_ff @(posedge clk or negedge rst_core_n) begin
    if (!rst_core_n) begin
      pend <= '0;
      {q_head, q_tail, q_count} <= 7'h0;
      for (int i = 0; i < QDEPTH; i++) begin
        queue[i] <= 9'h0;
      end
    end else begin
      pend <= (pend & ~evt_clr) | evt_set;
      if (push) begin
        queue[q_tail] <= evt_word;
        q_tail <= q_tail + 2'h1;
      end
      if (pop) begin
        q_head <= q_head + 2'h1;
      end
      q_count <= q_count + {2'h0, push} - {2'h0, pop};
    end
  end
  // =====================================================
  // Checks
  sequence s_bus_req;
    req && waitrequest && !tx_stall;
  endsequence
  sequence s_bus_done;
    !waitrequest ##1 waitrequest;
  endsequence
  AST_BUS_ANSWER: assert property (@(posedge clk) disable iff (!rst_core_n)
    s_bus_req |=> s_bus_done) else $error("bus answer not one cycle");
  AST_ALARM_QUEUED: assert property (@(posedge clk) disable iff (!rst_core_n)
    alarm_event && !alarm_mask |=> pend[0]) else $error("alarm not pending");
  AST_ALARM_MASKED: assert property (@(posedge clk) disable iff (!rst_core_n)
    $rose(pend[0]) |-> $past(!alarm_mask)) else $error("masked alarm queued");
  AST_ALARM_LEVEL: assert property (@(posedge clk) disable iff (!rst_core_n)
    ss7_en && ss7_cnt >= err_thr |=> alarm_prev) else $error("alarm level missed");
  AST_OWNED_DEACT: assert property (@(posedge clk) disable iff (!rst_core_n)
    tx_owned_err |=> !tx_active && line_tx && pend[2]) else $error("no deactivate after owned-buffer error");
  AST_CNT_CLEAR: assert property (@(posedge clk) disable iff (!rst_core_n)
    activate |=> ss7_cnt == 8'h0) else $error("counter not cleared");
  AST_SHORT_INC: assert property (@(posedge clk) disable iff (!rst_core_n)
    hard_err && !good_dec && !activate && ss7_cnt != CNT_MAX |=> ss7_cnt == $past(ss7_cnt) + 8'h1)
    else $error("error not counted");
  AST_TX_END_BUF: assert property (@(posedge clk) disable iff (!rst_core_n)
    tx_last && !wr_txd |=> !tx_owner && tx_cnt == 14'h0) else $error("transmit end of buffer wrong");
  AST_RX_END_BUF: assert property (@(posedge clk) disable iff (!rst_core_n)
    rx_last && !wr_rxd |=> !rx_owner ##0 rx_valid) else $error("receive end of buffer wrong");
  AST_FRAME_REC: assert property (@(posedge clk) disable iff (!rst_core_n)
    frame_rise && !frame_mask |=> pend[4] && rx_bits == 3'h0) else $error("frame recovery lost");
endmodule : sstm_channel

//--- dv/sstm_line_model.sv
// Purpose: Serial line partner for one channel
// Assumes: Line clock runs free, phase unrelated to clk
// Notes: Receive bits change on line clock fall, MSB first
`timescale 1ns/1ns
module sstm_line_model (
  output logic line_clk, // Serial clock
  output logic line_rx, // Receive data to device
  output logic line_in_frame, // In-frame level
  input wire logic line_tx, // Transmit data from device
  input wire logic frame_go, // Request frame recovery
  input wire logic [7:0] rx_byte, // Repeated receive octet
  output logic [7:0] tx_seen // Last eight line bits
);
  logic [2:0] idx;
  // ==========================================
  // Clock and data
  initial begin
    line_clk = 1'b0;
    line_rx = 1'b0;
    line_in_frame = 1'b0;
    idx = 3'h7;
    #137;
    forever #400 line_clk = ~line_clk;
  end
  always @(negedge line_clk) begin
    if (frame_go && !line_in_frame) begin
      line_in_frame <= 1'b1;
      line_rx <= rx_byte[7];
      idx <= 3'h6;
    end else if (line_in_frame) begin
      line_rx <= rx_byte[idx];
      idx <= idx - 3'h1;
    end else begin
      line_rx <= ~line_rx; // No stable level out of frame
    end
  end
  always @(posedge line_clk) begin
    tx_seen <= {tx_seen[6:0], line_tx};
  end
endmodule : sstm_line_model

//--- dv/test_ss7_error_rate_and_transparent_mode.sv
// Purpose: Self-checking bench for one SS7/transparent channel
// Assumes: Register bus reads are checked by a monitor against a queue
// Notes: Channel number 5 so the channel field is seen in events
`timescale 1ns/1ns
module test_ss7_error_rate_and_transparent_mode;
  import sstm_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, read = 1'b0, write = 1'b0, frame_go = 1'b0;
  logic [4:0] address = 5'h00;
  logic [31:0] writedata = 32'h0, readdata, rnd = 32'haf06144c, rdata;
  logic waitrequest, line_clk, line_rx, line_in_frame, line_tx, flag_hunt_restart;
  logic [4:0] ss7_in = 5'h00;
  logic [7:0] tx_seen;
  logic [32:0] expq[$];
  int errors = 0, compares = 0, hunts = 0;
  always #50 clk = ~clk;
  sstm_channel #(.CHANNEL_ID(4'h5)) DUT (.clk(clk), .rst_n(rst_n), .address(address), .read(read),
    .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .line_clk(line_clk), .line_rx(line_rx), .line_in_frame(line_in_frame), .line_tx(line_tx),
    .ss7_msg_ok(ss7_in[4]), .ss7_msg_short(ss7_in[3]), .ss7_msg_fcs(ss7_in[2]),
    .ss7_msg_align(ss7_in[1]), .ss7_octet_err(ss7_in[0]), .flag_hunt_restart(flag_hunt_restart));
  sstm_line_model partner (.line_clk(line_clk), .line_rx(line_rx), .line_in_frame(line_in_frame),
    .line_tx(line_tx), .frame_go(frame_go), .rx_byte(8'h6b), .tx_seen(tx_seen));
  // ==========================================
  // Checking and closing
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic tally_and_finish;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : tally_and_finish
  always @(posedge clk) begin
    if (flag_hunt_restart === 1'b1) hunts++;
    if (read === 1'b1 && waitrequest === 1'b0) begin
      if (expq.size() == 0) check("queue", 32'h1, 32'h0);
      else if (expq[0][32]) check("readdata", readdata, expq[0][31:0]);
      if (expq.size() != 0) void'(expq.pop_front());
    end
  end
  initial begin
    repeat (100000) @(posedge clk);
    errors++;
    tally_and_finish;
  end
  // ==========================================
  // Drivers
  function automatic logic [31:0] xs(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction : xs
  task automatic bus(input logic [4:0] a, input logic w, input logic [31:0] d, input logic [32:0] e);
    int n;
    n = 0;
    address <= a;
    write <= w;
    read <= !w;
    writedata <= d;
    if (!w) expq.push_back(e);
    do begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 200);
    rdata = readdata;
    if (n >= 200) begin
      errors++;
      tally_and_finish;
    end
    read <= 1'b0;
    write <= 1'b0;
    @(posedge clk);
  endtask : bus
  task automatic rd(input logic [4:0] a, input logic [31:0] e);
    bus(a, 1'b0, 32'h0, {1'b1, e});
  endtask : rd
  task automatic poll(input int b, input logic want);
    for (int i = 0; i < 80; i++) begin
      bus(ADDR_STATUS, 1'b0, 32'h0, 33'h0);
      if (rdata[b] === want) return;
    end
    errors++;
    tally_and_finish;
  endtask : poll
  task automatic pulse(input int which, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      ss7_in <= 5'h01 << which;
      @(posedge clk);
      ss7_in <= 5'h00;
      rnd = xs(rnd);
      repeat (rnd[1:0]) @(posedge clk);
    end
    // Counter, alarm and queue settle a few cycles after the strobe
    repeat (4) @(posedge clk);
  endtask : pulse
  // ==========================================
  // Scenarios
  initial begin
    logic ok;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rd(ADDR_CTRL, 32'h00001000);
    rd(ADDR_STATUS, 32'h00000010);
    rnd = xs(rnd);
    bus(5'h1c, 1'b1, rnd, 33'h0);
    rd(5'h1c, 32'h0);
    rd(ADDR_CTRL, 32'h00001000);
    bus(ADDR_CTRL, 1'b1, 32'h00000304, 33'h0);
    pulse(3, 1);
    pulse(2, 1);
    pulse(1, 1);
    rd(ADDR_STATUS, 32'h00000302);
    rd(ADDR_EVENT, 32'h000100a1);
    check("hunt", hunts, 32'h1);
    pulse(0, 15);
    rd(ADDR_STATUS, 32'h00000312);
    pulse(0, 1);
    rd(ADDR_STATUS, 32'h00000412);
    pulse(4, 255);
    rd(ADDR_STATUS, 32'h00000412);
    pulse(4, 1);
    rd(ADDR_STATUS, 32'h00000312);
    bus(ADDR_CTRL, 1'b1, 32'h0000050c, 33'h0);
    pulse(2, 2);
    rd(ADDR_STATUS, 32'h00000512);
    rd(ADDR_EVENT, 32'h0);
    // Transmit: end-of-message never set by the host side
    bus(ADDR_TX_DESC, 1'b1, 32'h0000c001, 33'h0);
    bus(ADDR_CTRL, 1'b1, 32'h00000521, 33'h0);
    rd(ADDR_STATUS, 32'h00000011);
    bus(ADDR_TX_DATA, 1'b1, 32'h0000001d, 33'h0);
    rd(ADDR_EVENT, 32'h000100b2);
    for (int i = 0; i < 400 && tx_seen !== 8'h1d; i++) @(posedge clk);
    check("tx octet", {24'h0, tx_seen}, 32'h1d);
    poll(0, 1'b0);
    rd(ADDR_EVENT, 32'h000100b3);
    // A deactivated channel must drop new data and keep idle code
    bus(ADDR_TX_DESC, 1'b1, 32'h0000c001, 33'h0);
    bus(ADDR_TX_DATA, 1'b1, 32'h00000000, 33'h0);
    ok = 1'b1;
    repeat (100) @(posedge clk) ok = ok & (line_tx === 1'b1);
    check("idle code", {31'h0, ok}, 32'h1);
    rd(ADDR_STATUS, 32'h00000010);
    bus(ADDR_CTRL, 1'b1, 32'h00000521, 33'h0);
    rd(ADDR_STATUS, 32'h00000011);
    // Receive after frame recovery
    bus(ADDR_RX_DESC, 1'b1, 32'h0000c001, 33'h0);
    bus(ADDR_CTRL, 1'b1, 32'h00000502, 33'h0);
    frame_go <= 1'b1;
    poll(3, 1'b1);
    rd(ADDR_RX_DATA, 32'h0000016b);
    rd(ADDR_EVENT, 32'h000100a4);
    rd(ADDR_EVENT, 32'h000100a2);
    tally_and_finish;
  end
endmodule : test_ss7_error_rate_and_transparent_mode
